// ===== spimsp_peer.sv
// Purpose: far slave on the master link
// Assumes: msb first, same clock mode as the port
// Notes: each further byte of a frame is the inverse of the last
`timescale 1ns/1ps
module spimsp_peer (
	// clock
	input wire logic clk,
	// link pins
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi,
	output logic miso,
	// mode and data
	input wire logic cpol,
	input wire logic cpha,
	input wire logic [7:0] tx_byte,
	output logic [7:0] rx_byte
);
	logic p_q;
	logic out_q;
	logic [7:0] sh_q;
	logic [7:0] cur_q;
	logic [7:0] acc_q;
	int n;
	wire edge_w = sclk != p_q;
	wire lead_w = edge_w && sclk != cpol;
	// unselected line shows the inverse of the first bit of tx_byte
	assign miso = out_q ^ ss_n;
	// sample on one edge, launch on the other
	always @(posedge clk) begin
		p_q <= sclk;
		if (ss_n) begin
			out_q <= tx_byte[7];
			cur_q <= tx_byte;
			sh_q <= cpha ? tx_byte : tx_byte << 1;
			n <= 0;
		end else if (edge_w && (lead_w ^ cpha)) begin
			acc_q <= {acc_q[6:0], mosi};
			n <= n + 1;
			if (n == 7) rx_byte <= {acc_q[6:0], mosi};
		end else if (edge_w && n == 8) begin
			out_q <= ~cur_q[7];
			cur_q <= ~cur_q;
			sh_q <= ~cur_q << 1;
			n <= 0;
		end else if (edge_w) begin
			out_q <= sh_q[7];
			sh_q <= sh_q << 1;
		end
	end
endmodule : spimsp_peer

// ===== spimsp_pkg.sv
// Purpose: constants and types for the serial peripheral port
// Assumes: 32-bit plain register port, byte addresses as printed
// Notes: the rule summary follows
// Contract
// - master drives clock and data out; slave reversed
// - eight bit full duplex exchange per transfer
// - master clock is 20.48 MHz over 2(1+divider)
// - divider floor 0x05 or 0x0B by setting
// - only core divider settings 0 and 1 supported
// - launch on one edge, sample on other
// - slave transfer framed by active low select
// - continuous mode holds select while data waits
// - single mode stalls before next waiting byte
// - loopback ties data out to data in
// - bits enable slave data and select drivers
// - overflow overwrites or discards by bit 8
// - underflow resends previous byte or zeros
// - bit 6 picks write or read start
// - bit 5 selects lsb or msb first
// - bit 3 sets clock idle level
// - bit 2 sets clock phase
// - bit 1 master select, bit 0 enable
// - receive full, overflow, their or; read clears
// - underflow and transmit request flags and clearing
// - transmit busy set by write, clears empty
// - divider register 8 bits, resets to 0x1B
// - transmit register write only, next byte out
package spimsp_pkg;
	// register byte addresses
	localparam logic [31:0] ADDR_STATUS = 32'hFFFF0A00;
	localparam logic [31:0] ADDR_RX = 32'hFFFF0A04;
	localparam logic [31:0] ADDR_TX = 32'hFFFF0A08;
	localparam logic [31:0] ADDR_DIV = 32'hFFFF0A0C;
	localparam logic [31:0] ADDR_CTRL = 32'hFFFF0A10;
	// control bit positions
	localparam int CB_CONT = 12;
	localparam int CB_LOOP = 11;
	localparam int CB_SOE = 10;
	localparam int CB_SSOE = 9;
	localparam int CB_OVW = 8;
	localparam int CB_UFM = 7;
	localparam int CB_TIM = 6;
	localparam int CB_LSB = 5;
	localparam int CB_CPOL = 3;
	localparam int CB_CPHA = 2;
	localparam int CB_MST = 1;
	localparam int CB_EN = 0;
	localparam logic [15:0] CTRL_MASK = 16'h1FEF;
	// reset values
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] RX_RESET = 8'h00;
	localparam logic [7:0] DIV_RESET = 8'h1B;
	// divider floors per core clock divider setting
	localparam logic [7:0] DIV_MIN_CD0 = 8'h05;
	localparam logic [7:0] DIV_MIN_CD1 = 8'h0B;
	// timing: reference rate of the divider and core rate, in kHz
	localparam int REF_KHZ = 20480;
	localparam int CLK_KHZ = 200000;
	localparam logic [17:0] ACC_STEP = 18'(REF_KHZ);
	localparam logic [17:0] ACC_WRAP = 18'(CLK_KHZ);
	localparam logic [3:0] HALVES_LAST = 4'hF;
	localparam logic [1:0] STALL_LAST = 2'h1;
	localparam logic [3:0] BIT_LAST = 4'h7;
	// master sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_XFER = 2'b01,
		ST_STALL = 2'b11
	} spimsp_state_t;
endpackage : spimsp_pkg

// ===== spimsp_top.sv
// Purpose: master/slave serial peripheral port with register access
// Assumes: pin inputs synchronous to clk; one clock domain
// Notes: read data valid one cycle after the read strobe
`timescale 1ns/1ps
module spimsp_top import spimsp_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [31:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	// core clock divider setting from the power block
	input wire logic [2:0] core_clock_divider_setting,
	// serial clock pin
	input wire logic sclk_i,
	output logic sclk_o,
	output logic sclk_oe_n,
	// master out slave in pin
	input wire logic mosi_i,
	output logic mosi_o,
	output logic mosi_oe_n,
	// master in slave out pin
	input wire logic miso_i,
	output logic miso_o,
	output logic miso_oe_n,
	// select pin
	input wire logic ss_n_i,
	output logic ss_n_o,
	output logic ss_oe_n
);

	// bit position within the byte for a given count
	function automatic logic [2:0] bit_pos(input logic [3:0] i, input logic lsb_first);
		bit_pos = lsb_first ? i[2:0] : 3'h7 - i[2:0];
	endfunction : bit_pos

	logic [15:0] ctrl_q;
	logic [7:0] div_q;
	logic [7:0] tx_hold_q;
	logic tx_pend_q;
	logic tx_sent_q;
	logic [7:0] tx_prev_q;
	logic [7:0] tx_buf_q;
	logic [7:0] rx_sh_q;
	logic [7:0] rx_sh_d;
	logic [7:0] rx_q;
	logic rx_full_q;
	logic ovf_q;
	logic tx_uf_q;
	logic tx_irq_q;
	logic st0_prev_q;
	logic [3:0] bit_q;
	logic [3:0] lidx_q;
	logic out_q;
	spimsp_state_t state_q;
	logic [3:0] hcnt_q;
	logic [7:0] hdiv_q;
	logic [1:0] scnt_q;
	logic [17:0] acc_q;
	logic ref_tick;
	logic sclk_q;
	logic sclk_prev_q;
	logic ss_prev_q;
	logic [31:0] rd_data_q;
	logic sclk_oe_n_q;
	logic mosi_oe_n_q;
	logic miso_oe_n_q;
	logic ss_n_o_q;
	logic ss_oe_n_q;

	// address decode
	logic wr_ctrl, wr_div, wr_tx, rd_rx;
	assign wr_ctrl = wr_en && (addr == ADDR_CTRL);
	assign wr_div = wr_en && (addr == ADDR_DIV);
	assign wr_tx = wr_en && (addr == ADDR_TX);
	assign rd_rx = rd_en && (addr == ADDR_RX);

	// control fields
	logic en, mst, cpol, cpha, lsb, cont, loop, ovw, ufm, tim;
	assign en = ctrl_q[CB_EN];
	assign mst = ctrl_q[CB_MST];
	assign cpol = ctrl_q[CB_CPOL];
	assign cpha = ctrl_q[CB_CPHA];
	assign lsb = ctrl_q[CB_LSB];
	assign cont = ctrl_q[CB_CONT];
	assign loop = ctrl_q[CB_LOOP];
	assign ovw = ctrl_q[CB_OVW];
	assign ufm = ctrl_q[CB_UFM];
	assign tim = ctrl_q[CB_TIM];

	// effective divider clamped to the floor of the core clock setting
	logic [7:0] div_min, eff_div;
	assign div_min = (core_clock_divider_setting == 3'h0) ? DIV_MIN_CD0 : DIV_MIN_CD1;
	assign eff_div = (div_q < div_min) ? div_min : div_q;

	// status view
	logic st_tx_busy;
	logic [7:0] status;
	assign st_tx_busy = tx_pend_q | tx_sent_q;
	assign status = {2'b00, ovf_q, rx_full_q | ovf_q, rx_full_q, tx_uf_q, tx_irq_q,
		st_tx_busy};

	// reference tick generator at 20.48 MHz out of the core clock
	logic [17:0] acc_sum;
	assign acc_sum = acc_q + ACC_STEP;
	assign ref_tick = (acc_sum >= ACC_WRAP);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			acc_q <= 18'h00000;
		end else if (ref_tick) begin
			acc_q <= acc_sum - ACC_WRAP;
		end else begin
			acc_q <= acc_sum;
		end
	end

	// half period strobe: eff_div+1 reference ticks per half
	logic h_ev;
	assign h_ev = ref_tick && (hdiv_q == eff_div);

	// master event decode
	logic m_go, m_edge, m_last, m_cont, m_load, m_lead, m_trail;
	assign m_go = en && mst && (tim ? tx_pend_q : rd_rx);
	assign m_edge = (state_q == ST_XFER) && h_ev;
	assign m_last = m_edge && (hcnt_q == HALVES_LAST);
	assign m_cont = cont && tx_pend_q;
	assign m_load = ((state_q == ST_IDLE) && m_go) || (m_last && m_cont);
	assign m_lead = m_edge && (sclk_q == cpol);
	assign m_trail = m_edge && (sclk_q != cpol);

	// slave event decode from the pin clock and select
	logic s_act, s_start, s_lead, s_trail;
	assign s_act = en && !mst && !ss_n_i;
	assign s_start = en && !mst && ss_prev_q && !ss_n_i;
	assign s_lead = s_act && (sclk_prev_q == cpol) && (sclk_i != cpol);
	assign s_trail = s_act && (sclk_prev_q != cpol) && (sclk_i == cpol);

	// common bit engine events
	logic load, lead, trail, launch, sample, done, in_bit, uf_ev;
	logic [7:0] tx_src;
	assign load = mst ? m_load : s_start;
	assign lead = mst ? m_lead : s_lead;
	assign trail = mst ? m_trail : s_trail;
	assign launch = cpha ? lead : (trail && (lidx_q <= BIT_LAST));
	assign sample = cpha ? trail : lead;
	assign done = sample && (bit_q == BIT_LAST);
	assign in_bit = loop ? out_q : (mst ? miso_i : mosi_i);
	assign tx_src = tx_pend_q ? tx_hold_q : (ufm ? tx_prev_q : 8'h00);
	assign uf_ev = load && !tx_pend_q;

	// receive shift with the current bit inserted
	always_comb begin
		rx_sh_d = rx_sh_q;
		rx_sh_d[bit_pos(bit_q, lsb)] = in_bit;
	end

	// control and divider registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= CTRL_RESET;
			div_q <= DIV_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= wr_data[15:0] & CTRL_MASK;
			end
			if (wr_div) begin
				div_q <= wr_data[7:0];
			end
		end
	end

	// master sequencer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			hcnt_q <= 4'h0;
			hdiv_q <= 8'h00;
			scnt_q <= 2'h0;
			sclk_q <= 1'b0;
		end else if (!en || !mst) begin
			state_q <= ST_IDLE;
			hcnt_q <= 4'h0;
			hdiv_q <= 8'h00;
			scnt_q <= 2'h0;
			sclk_q <= cpol;
		end else begin
			if (h_ev || state_q == ST_IDLE) begin
				hdiv_q <= 8'h00;
			end else if (ref_tick) begin
				hdiv_q <= hdiv_q + 8'h01;
			end
			case (state_q)
				ST_IDLE: begin
					sclk_q <= cpol;
					hcnt_q <= 4'h0;
					scnt_q <= 2'h0;
					if (m_go) begin
						state_q <= ST_XFER;
					end
				end
				ST_XFER: begin
					if (m_edge) begin
						sclk_q <= ~sclk_q;
						hcnt_q <= hcnt_q + 4'h1;
						if (m_last && !m_cont) begin
							state_q <= ST_STALL;
						end
					end
				end
				ST_STALL: begin
					sclk_q <= cpol;
					if (h_ev) begin
						scnt_q <= scnt_q + 2'h1;
						if (scnt_q == STALL_LAST) begin
							state_q <= ST_IDLE;
						end
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// shift engine: load, launch and sample
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_buf_q <= 8'h00;
			tx_prev_q <= 8'h00;
			rx_sh_q <= 8'h00;
			bit_q <= 4'h0;
			lidx_q <= 4'h0;
			out_q <= 1'b0;
		end else if (load) begin
			tx_buf_q <= tx_src;
			tx_prev_q <= tx_src;
			rx_sh_q <= 8'h00;
			bit_q <= 4'h0;
			if (!cpha) begin
				out_q <= tx_src[bit_pos(4'h0, lsb)];
				lidx_q <= 4'h1;
			end else begin
				lidx_q <= 4'h0;
			end
		end else begin
			if (launch) begin
				out_q <= tx_buf_q[bit_pos(lidx_q, lsb)];
				lidx_q <= lidx_q + 4'h1;
			end
			if (sample) begin
				rx_sh_q <= rx_sh_d;
				bit_q <= bit_q + 4'h1;
			end
		end
	end

	// transmit holding register and busy flags
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_hold_q <= 8'h00;
			tx_pend_q <= 1'b0;
			tx_sent_q <= 1'b0;
		end else begin
			if (wr_tx) begin
				tx_hold_q <= wr_data[7:0];
			end
			if (wr_tx) begin
				tx_pend_q <= 1'b1;
			end else if (load) begin
				tx_pend_q <= 1'b0;
			end
			if (load) begin
				tx_sent_q <= tx_pend_q;
			end else if (done || !en) begin
				tx_sent_q <= 1'b0;
			end
		end
	end

	// transmit status flags, set wins over clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tx_uf_q <= 1'b0;
			tx_irq_q <= 1'b0;
			st0_prev_q <= 1'b0;
		end else begin
			st0_prev_q <= st_tx_busy;
			if (uf_ev) begin
				tx_uf_q <= 1'b1;
			end else if (wr_tx) begin
				tx_uf_q <= 1'b0;
			end
			if (uf_ev || (st0_prev_q && !st_tx_busy)) begin
				tx_irq_q <= 1'b1;
			end else if (wr_tx || (!en && !st_tx_busy)) begin
				tx_irq_q <= 1'b0;
			end
		end
	end

	// receive register and flags, a new byte wins over a read clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_q <= RX_RESET;
			rx_full_q <= 1'b0;
			ovf_q <= 1'b0;
		end else begin
			if (done && (!rx_full_q || ovw || rd_rx)) begin
				rx_q <= rx_sh_d;
			end
			if (done) begin
				rx_full_q <= 1'b1;
			end else if (rd_rx) begin
				rx_full_q <= 1'b0;
			end
			if (done && rx_full_q && !rd_rx) begin
				ovf_q <= 1'b1;
			end else if (rd_rx) begin
				ovf_q <= 1'b0;
			end
		end
	end

	// pin history for slave edge and select detection
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_prev_q <= 1'b0;
			ss_prev_q <= 1'b1;
		end else begin
			sclk_prev_q <= sclk_i;
			ss_prev_q <= ss_n_i;
		end
	end

	// pin drivers and enables, low enable means driving
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sclk_oe_n_q <= 1'b1;
			mosi_oe_n_q <= 1'b1;
			miso_oe_n_q <= 1'b1;
			ss_n_o_q <= 1'b1;
			ss_oe_n_q <= 1'b1;
		end else begin
			sclk_oe_n_q <= !(en && mst);
			mosi_oe_n_q <= !(en && mst);
			miso_oe_n_q <= !(en && !mst && ctrl_q[CB_SOE] && !ss_n_i);
			ss_n_o_q <= !(state_q == ST_XFER || m_load);
			ss_oe_n_q <= !(en && mst && ctrl_q[CB_SSOE]);
		end
	end

	// read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data_q <= 32'h00000000;
		end else if (rd_en) begin
			case (addr)
				ADDR_STATUS: rd_data_q <= {24'h000000, status};
				ADDR_RX: rd_data_q <= {24'h000000, rx_q};
				ADDR_DIV: rd_data_q <= {24'h000000, div_q};
				ADDR_CTRL: rd_data_q <= {16'h0000, ctrl_q};
				default: rd_data_q <= 32'h00000000;
			endcase
		end else begin
			rd_data_q <= 32'h00000000;
		end
	end

	// outputs from flip-flops
	assign rd_data = rd_data_q;
	assign sclk_o = sclk_q;
	assign sclk_oe_n = sclk_oe_n_q;
	assign mosi_o = out_q;
	assign mosi_oe_n = mosi_oe_n_q;
	assign miso_o = out_q;
	assign miso_oe_n = miso_oe_n_q;
	assign ss_n_o = ss_n_o_q;
	assign ss_oe_n = ss_oe_n_q;

endmodule : spimsp_top

// ===== spimsp_top_properties.sv
// Purpose: port checks of spimsp_top
// Assumes: one clock domain
// Notes: bound at the foot
`timescale 1ns/1ps
module spimsp_chk import spimsp_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// register port
	input wire logic [31:0] addr,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [31:0] rd_data,
	// pins
	input wire logic sclk_o,
	input wire logic sclk_oe_n,
	input wire logic mosi_oe_n,
	input wire logic miso_oe_n,
	input wire logic ss_n_i,
	input wire logic ss_n_o,
	input wire logic ss_oe_n
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	logic [7:0] tog_q;
	logic sclk_p_q;
	logic ss_p_q;
	wire st_rd = rd_en && addr == ADDR_STATUS;
	// clock edges of the current frame; cleared once select idles
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tog_q <= 8'h00;
			sclk_p_q <= 1'b0;
			ss_p_q <= 1'b1;
		end else begin
			sclk_p_q <= sclk_o;
			ss_p_q <= ss_n_o;
			if (ss_n_o && ss_p_q) begin
				tog_q <= 8'h00;
			end else if (sclk_o != sclk_p_q) begin
				tog_q <= tog_q + 8'h01;
			end
		end
	end
	frame_bits_a: assert property ($rose(ss_n_o) |=> tog_q[3:0] == 4'h0 && tog_q != 8'h00)
		else $error("frame not whole bytes");
	clk_idle_a: assert property (ss_n_o && $past(ss_n_o) && !$past(wr_en) && !$past(wr_en, 2)
		|-> $stable(sclk_o)) else $error("clock moved outside frame");
	master_dir_a: assert property (!sclk_oe_n |-> !mosi_oe_n && miso_oe_n)
		else $error("master pin directions");
	ss_drive_a: assert property (!ss_oe_n |-> !sclk_oe_n)
		else $error("select driven outside master");
	slave_out_a: assert property (!miso_oe_n |-> $past(!ss_n_i) && sclk_oe_n)
		else $error("slave data driven wrongly");
	irq_or_a: assert property (st_rd |=> rd_data[4] == (rd_data[3] | rd_data[5]))
		else $error("receive flag not or");
	tx_req_a: assert property (st_rd |=> !rd_data[2] || rd_data[1])
		else $error("underflow without request");
	tx_wo_a: assert property (rd_en && addr == ADDR_TX |=> rd_data == 32'h0)
		else $error("transmit read not zero");
	ctrl_rsv_a: assert property (rd_en && addr == ADDR_CTRL |=> (rd_data & ~32'(CTRL_MASK)) == 32'h0)
		else $error("reserved control bits");
	frame_c: cover property ($rose(ss_n_o));
	ovf_c: cover property (st_rd ##1 rd_data[5]);
	slave_c: cover property (!miso_oe_n);
endmodule : spimsp_chk
bind spimsp_top spimsp_chk u_chk (.clk, .rst, .addr, .wr_en, .rd_en, .rd_data, .sclk_o,
	.sclk_oe_n, .mosi_oe_n, .miso_oe_n, .ss_n_i, .ss_n_o, .ss_oe_n);

// ===== tb_top.sv
// Purpose: self-checking bench of spimsp_top
// Assumes: peer model as far slave
// Notes: expectations from integer models
`timescale 1ns/1ps
module tb_top import spimsp_pkg::*; ;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [31:0] addr = 32'h0;
	logic [31:0] wr_data = 32'h0;
	logic [31:0] rd_data;
	logic [2:0] cd = 3'h0;
	logic sclk_o, sclk_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, ss_n_o, ss_oe_n, p_miso;
	logic ss_drv_n = 1'b1;
	// far master clock offset from idle and data, used only in slave mode
	logic s_clk = 1'b0;
	logic s_mosi = 1'b0;
	logic ss_q = 1'b1;
	logic cpol = 1'b0;
	logic cpha = 1'b0;
	logic [7:0] p_tx = 8'h00;
	logic [7:0] p_rx;
	int n_mismatch = 0;
	int num_checks = 0;
	int flen = 0;
	int nfall = 0;
	logic [63:0] rtab [6] = '{{ADDR_STATUS, 32'h0}, {ADDR_RX, 32'h0}, {ADDR_TX, 32'h0},
		{ADDR_DIV, 32'h1B}, {ADDR_CTRL, 32'h0}, {32'hFFFF0A14, 32'h0}};
	// wire levels from all drivers
	wire sclk_w = sclk_oe_n ? cpol ^ s_clk : sclk_o;
	wire mosi_w = mosi_oe_n ? (ss_drv_n ? ~mosi_o : s_mosi) : mosi_o;
	wire miso_w = miso_oe_n ? p_miso : miso_o;
	wire ss_w = ss_oe_n ? ss_drv_n : ss_n_o;
	spimsp_top u_dut (.clk, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
		.core_clock_divider_setting(cd), .sclk_i(sclk_w), .sclk_o, .sclk_oe_n,
		.mosi_i(mosi_w), .mosi_o, .mosi_oe_n, .miso_i(miso_w), .miso_o, .miso_oe_n,
		.ss_n_i(ss_w), .ss_n_o, .ss_oe_n);
	spimsp_peer u_peer (.clk, .sclk(sclk_w), .ss_n(ss_w), .mosi(mosi_w), .miso(p_miso),
		.cpol, .cpha, .tx_byte(p_tx), .rx_byte(p_rx));
	// core clock
	initial begin
		forever #2.5 clk = ~clk;
	end
	// frame length and frame starts
	always @(posedge clk) begin
		ss_q <= ss_w;
		if (!ss_w) flen <= flen + 1;
		if (ss_q && !ss_w) nfall <= nfall + 1;
	end
	task automatic wr(input logic [31:0] a, d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask : rd
	task automatic chk(input logic [31:0] g, e, input string m);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %0h exp %0h", $time, m, g, e);
		end
	endtask : chk
	task automatic rchk(input logic [31:0] a, e, input string m);
		logic [31:0] d;
		rd(a, d);
		chk(d, e, m);
	endtask : rchk
	// poll until received and nothing left to send
	task automatic wait_done();
		logic [31:0] s;
		s = 32'h0;
		for (int i = 0; i < 4000 && !(s[3] && !s[0]); i++) rd(ADDR_STATUS, s);
		chk(32'(s[3] && !s[0]), 32'h1, "done");
		// let the last half period and the stall run out before the next step
		repeat (400) @(posedge clk);
	endtask : wait_done
	function automatic logic [7:0] ord(input logic [7:0] b, input bit l);
		return l ? {<<{b}} : b;
	endfunction : ord
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : stop_test
	// main sequence
	initial begin
		logic [31:0] c;
		logic [7:0] t, tn, pb, pn;
		int e, f0, n0;
		logic [7:0] got;
		bit lb;
		void'($urandom(93));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		foreach (rtab[i]) rchk(rtab[i][63:32], rtab[i][31:0], "reset");
		wr(ADDR_CTRL, 32'hFFFF);
		rchk(ADDR_CTRL, 32'(CTRL_MASK), "ctrl");
		wr(ADDR_STATUS, 32'hFF);
		wr(ADDR_CTRL, 32'h0);
		rchk(ADDR_STATUS, 32'h0, "ro");
		wr(ADDR_DIV, 32'h05);
		rchk(ADDR_DIV, 32'h05, "div");
		$display("test registers done");
		for (int m = 0; m < 8; m++) begin
			cd <= 3'($urandom % 2);
			{cpol, cpha} <= 2'(m);
			t = 8'($urandom);
			pb = 8'($urandom);
			p_tx <= pb;
			lb = (m == 3 || m == 6);
			c = 32'h243 | 32'(m % 4) << 2 | 32'(m / 4) << 5 | 32'(lb) << 11;
			wr(ADDR_CTRL, c);
			f0 = flen;
			wr(ADDR_TX, 32'(t));
			wait_done();
			e = 16 * ((cd[0] ? 11 : 5) + 1) * 10000 / 1024;
			chk(32'(flen - f0 > e - e / 16 && flen - f0 < e + e / 16), 32'h1, "rate");
			chk(p_rx, ord(t, m[2]), "peer");
			rchk(ADDR_STATUS, 32'h1A, "flags");
			rchk(ADDR_RX, 32'(lb ? t : ord(pb, m[2])), "rx");
			rchk(ADDR_STATUS, 32'h02, "clear");
			$display("test mode %0d done", m);
		end
		for (int k = 0; k < 3; k++) begin
			t = 8'($urandom);
			tn = ~t;
			pb = 8'($urandom);
			pn = ~pb;
			p_tx <= pb;
			{cpol, cpha} <= 2'b00;
			wr(ADDR_CTRL, 32'h243 | (k < 2 ? 32'h1000 : 32'h0) | 32'(k == 1) << 8);
			n0 = nfall;
			wr(ADDR_TX, 32'(t));
			repeat (20) @(posedge clk);
			wr(ADDR_TX, 32'(tn));
			wait_done();
			chk(32'(nfall - n0), k < 2 ? 32'h1 : 32'h2, "frames");
			chk(p_rx, tn, "peer");
			rchk(ADDR_STATUS, 32'h3A, "ovf");
			rchk(ADDR_RX, 32'(k == 1 ? pn : pb), "rx");
			$display("test pair %0d done", k);
		end
		for (int u = 1; u >= 0; u--) begin
			wr(ADDR_CTRL, 32'h203 | 32'(u) << 7);
			rd(ADDR_RX, c);
			wait_done();
			chk(p_rx, u ? tn : 8'h00, "under");
			rchk(ADDR_STATUS, 32'h1E, "flags");
			$display("test underflow %0d done", u);
		end
		wr(ADDR_CTRL, 32'h401);
		rd(ADDR_RX, c);
		t = 8'($urandom);
		pb = 8'($urandom);
		wr(ADDR_TX, 32'(t));
		ss_drv_n <= 1'b0;
		repeat (4) @(posedge clk);
		#1 chk({miso_oe_n, sclk_oe_n}, 32'h1, "slave");
		// far master: eight cycles per bit, well below a quarter of the core rate
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk);
			s_mosi <= pb[i];
			repeat (3) @(posedge clk);
			got = {got[6:0], miso_w};
			s_clk <= 1'b1;
			repeat (4) @(posedge clk);
			s_clk <= 1'b0;
		end
		repeat (4) @(posedge clk);
		ss_drv_n <= 1'b1;
		chk(32'(got), 32'(t), "slave out");
		rchk(ADDR_STATUS, 32'h1A, "slave flags");
		rchk(ADDR_RX, 32'(pb), "slave in");
		$display("test slave done");
		stop_test();
	end
	// watchdog: the tests need well under half of this span
	initial begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		stop_test();
	end
endmodule : tb_top
